// [logic/dlt_prescaler.sv]
// prescaled tick generator
`include "dlt_consts.svh"
module dlt_prescaler
    import dlt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] scale,
    output logic tick
);
    typedef struct packed {
        dlt_byte_t cnt;
        logic tick;
    } dlt_ps_s;

    dlt_ps_s q, d;
    dlt_byte_t limit;

    always_comb begin
        case (scale)
            2'd0: limit = `DLT_DIV12;
            2'd1: limit = `DLT_DIV4;
            2'd2: limit = `DLT_DIV48;
            default: limit = `DLT_DIV8;
        endcase
        d = q;
        d.tick = 1'b0;
        if (q.cnt >= limit) begin
            d.cnt = `DLT_RESET_BYTE;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 8'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : dlt_prescaler

// [logic/dlt_timers.sv]
// dual legacy counter/timer with axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`include "dlt_consts.svh"
module dlt_timers
    import dlt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_pin_a,
    input wire logic event_pin_b,
    input wire logic ext_irq_a_n,
    input wire logic ext_irq_b_n,
    output logic timer_irq_a,
    output logic timer_irq_b,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic overflow_pulse_b
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        dlt_byte_t timer_control_status;
        dlt_byte_t timer_mode_reg;
        dlt_byte_t clock_select_reg;
        dlt_byte_t count_low_a;
        dlt_byte_t count_high_a;
        dlt_byte_t count_low_b;
        dlt_byte_t count_high_b;
        logic [1:0] irq_enable;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic irq_a;
        logic irq_b;
        logic xirq_a;
        logic xirq_b;
        logic ovf_b;
    } dlt_s;

    dlt_s q, d;
    logic ps_tick;

    dlt_prescaler u_ps (
        .aclk(aclk),
        .aresetn(aresetn),
        .scale(q.clock_select_reg[`DLT_SCA_HI:`DLT_SCA_LO]),
        .tick(ps_tick)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic tick_of(input logic ct, input logic sys, input logic fall,
                                     input logic pst);
        if (ct) begin
            tick_of = fall; // RULE1
        end else begin
            tick_of = sys ? 1'b1 : pst; // RULE2
        end
    endfunction : tick_of

    function automatic logic [7:0] reg_read(input logic [7:0] a, input dlt_s s);
        case (a)
            `DLT_ADDR_CTRL: reg_read = s.timer_control_status;
            `DLT_ADDR_MODE: reg_read = s.timer_mode_reg;
            `DLT_ADDR_CKSEL: reg_read = s.clock_select_reg;
            `DLT_ADDR_CLA: reg_read = s.count_low_a;
            `DLT_ADDR_CHA: reg_read = s.count_high_a;
            `DLT_ADDR_CLB: reg_read = s.count_low_b;
            `DLT_ADDR_CHB: reg_read = s.count_high_b;
            `DLT_ADDR_IEN: reg_read = {6'h00, s.irq_enable};
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `DLT_ADDR_CTRL, `DLT_ADDR_MODE, `DLT_ADDR_CKSEL, `DLT_ADDR_CLA, `DLT_ADDR_CHA,
            `DLT_ADDR_CLB, `DLT_ADDR_CHB, `DLT_ADDR_IEN, `DLT_ADDR_ACK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // one counting step of a timer in modes 0..2; returns {ovf, high, low}
    function automatic logic [16:0] step(input dlt_mode_e m, input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [16:0] r;
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        r = {1'b0, hi, lo};
        c13 = {1'b0, hi, lo[4:0]} + 14'd1;
        c16 = {1'b0, hi, lo} + 17'd1;
        c8 = {1'b0, lo} + 9'd1;
        case (m)
            DLT_M13: r = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // RULE17
            DLT_M16: r = c16; // RULE6
            DLT_M8R: r = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]}; // RULE7
            default: r = {1'b0, hi, lo};
        endcase
        step = r;
    endfunction : step

    // ----------------------------------------
    // next state
    // ----------------------------------------
    dlt_mode_e mode_a;
    dlt_mode_e mode_b;
    logic split;
    logic [3:0] fall;
    logic run_a;
    logic run_b;
    logic tk_a;
    logic tk_b;
    logic tk_ah;
    logic ovf_a;
    logic ovf_bt;
    logic ovf_ah;
    logic [16:0] sa;
    logic [16:0] sb;
    logic [8:0] lo8;
    logic [8:0] hi8;
    logic wr_fire;
    logic [7:0] wb;
    logic [7:0] tcs;

    always_comb begin
        d = q;
        mode_a = dlt_mode_e'(q.timer_mode_reg[`DLT_MODE_A_HI:`DLT_MODE_A_LO]); // RULE18
        mode_b = dlt_mode_e'(q.timer_mode_reg[`DLT_MODE_B_HI:`DLT_MODE_B_LO]);
        split = (mode_a == DLT_MSPLIT);
        // sync bits: 0 event a, 1 event b, 2 irq a, 3 irq b
        d.sync1 = {ext_irq_b_n, ext_irq_a_n, event_pin_b, event_pin_a}; // RULE20
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        fall = q.prev & ~q.sync2; // RULE20 RULE19
        run_a = q.timer_control_status[`DLT_TR_A] &
                (~q.timer_mode_reg[`DLT_GATE_A] | q.sync2[2]); // RULE3 RULE4
        run_b = q.timer_control_status[`DLT_TR_B] &
                (~q.timer_mode_reg[`DLT_GATE_B] | q.sync2[3]); // RULE5
        if (split) begin
            run_b = (mode_b != DLT_MSPLIT); // RULE12 RULE11
        end
        tk_a = run_a & tick_of(q.timer_mode_reg[`DLT_CT_A],
                               q.clock_select_reg[`DLT_SYSSEL_A], fall[0], ps_tick);
        tk_b = run_b & tick_of(q.timer_mode_reg[`DLT_CT_B] & ~split,
                               q.clock_select_reg[`DLT_SYSSEL_B], fall[1], ps_tick); // RULE11
        tk_ah = q.timer_control_status[`DLT_TR_B] &
                tick_of(1'b0, q.clock_select_reg[`DLT_SYSSEL_A], 1'b0, ps_tick); // RULE10
        ovf_a = 1'b0;
        ovf_bt = 1'b0;
        ovf_ah = 1'b0;
        sa = step(mode_a, q.count_low_a, q.count_high_a);
        sb = step(mode_b, q.count_low_b, q.count_high_b);
        lo8 = {1'b0, q.count_low_a} + 9'd1;
        hi8 = {1'b0, q.count_high_a} + 9'd1;
        if (split) begin
            if (tk_a) begin
                d.count_low_a = lo8[7:0]; // RULE9
                ovf_a = lo8[8];
            end
            if (tk_ah) begin
                d.count_high_a = hi8[7:0]; // RULE10
                ovf_ah = hi8[8];
            end
        end else if (tk_a) begin
            d.count_low_a = sa[7:0];
            d.count_high_a = sa[15:8];
            ovf_a = sa[16];
        end
        if (tk_b && mode_b != DLT_MSPLIT) begin
            d.count_low_b = sb[7:0];
            d.count_high_b = sb[15:8];
            ovf_bt = sb[16];
        end
        d.ovf_b = ovf_bt;
        // ----------------------------------------
        // axi4-lite handshake
        // ----------------------------------------
        if (s_axi_awvalid && !q.aw_got) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        wr_fire = q.aw_got & q.w_got & ~q.bvalid;
        wb = q.wdata[7:0];
        tcs = q.timer_control_status;
        // ----------------------------------------
        // flags: hardware set beats software clear
        // ----------------------------------------
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = addr_ok(q.aw_addr) ? `DLT_RESP_OKAY : `DLT_RESP_SLVERR;
            if (q.wstrb[0]) begin
                case (q.aw_addr)
                    `DLT_ADDR_CTRL: tcs = wb;
                    `DLT_ADDR_MODE: d.timer_mode_reg = wb;
                    `DLT_ADDR_CKSEL: d.clock_select_reg = wb & 8'h1B;
                    `DLT_ADDR_CLA: d.count_low_a = wb; // RULE21
                    `DLT_ADDR_CHA: d.count_high_a = wb; // RULE21
                    `DLT_ADDR_CLB: d.count_low_b = wb; // RULE21
                    `DLT_ADDR_CHB: d.count_high_b = wb; // RULE21
                    `DLT_ADDR_IEN: d.irq_enable = wb[1:0];
                    `DLT_ADDR_ACK: begin
                        // vector acknowledge: bit0 timer a, bit1 timer b, bit2/3 ext
                        if (wb[0]) tcs[`DLT_TF_A] = 1'b0; // RULE13
                        if (wb[1]) tcs[`DLT_TF_B] = 1'b0; // RULE13
                        if (wb[2] && q.timer_control_status[`DLT_IT_A]) tcs[`DLT_IE_A] = 1'b0;
                        if (wb[3] && q.timer_control_status[`DLT_IT_B]) tcs[`DLT_IE_B] = 1'b0;
                    end
                    default: tcs = q.timer_control_status;
                endcase
            end
        end
        if (ovf_a) begin
            tcs[`DLT_TF_A] = 1'b1; // RULE13 RULE9
        end
        if (ovf_ah || (ovf_bt && !split)) begin
            tcs[`DLT_TF_B] = 1'b1; // RULE10 RULE11
        end
        if (tcs[`DLT_IT_A]) begin
            if (fall[2]) tcs[`DLT_IE_A] = 1'b1; // RULE14 RULE16
        end else begin
            tcs[`DLT_IE_A] = ~q.sync2[2]; // RULE15 RULE16
        end
        if (tcs[`DLT_IT_B]) begin
            if (fall[3]) tcs[`DLT_IE_B] = 1'b1; // RULE14
        end else begin
            tcs[`DLT_IE_B] = ~q.sync2[3]; // RULE15
        end
        d.timer_control_status = tcs;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, reg_read(s_axi_araddr, q)};
            d.rresp = addr_ok(s_axi_araddr) ? `DLT_RESP_OKAY : `DLT_RESP_SLVERR;
        end
        d.irq_a = q.timer_control_status[`DLT_TF_A] & q.irq_enable[0]; // RULE8
        d.irq_b = q.timer_control_status[`DLT_TF_B] & q.irq_enable[1]; // RULE8
        d.xirq_a = q.timer_control_status[`DLT_IE_A];
        d.xirq_b = q.timer_control_status[`DLT_IE_B];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.sync1 <= 4'hF;
            q.sync2 <= 4'hF;
            q.prev <= 4'hF;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = ~q.aw_got;
    assign s_axi_wready = ~q.w_got;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign timer_irq_a = q.irq_a;
    assign timer_irq_b = q.irq_b;
    assign ext_irq_a = q.xirq_a;
    assign ext_irq_b = q.xirq_b;
    assign overflow_pulse_b = q.ovf_b;
endmodule : dlt_timers

// [pkg/dlt_consts.svh]
// constants for the dual legacy counter/timer block
// Overview of operation
// RULE1: source bit set counts event pin falling edges
// RULE2: else system clock or prescaled clock selected
// RULE3: count when run and (no gate or pin high)
// RULE4: run bit never clears the count
// RULE5: timer b mirrors timer a with own bits
// RULE6: mode 1 is full sixteen-bit counter
// RULE7: mode 2 low counts, reloads from high
// RULE8: overflow flag with enable raises interrupt request
// RULE9: mode 3 low byte uses timer a bits
// RULE10: mode 3 high byte runs on b run bit
// RULE11: split mode: b counts clock, no flag, overflow out
// RULE12: split mode: b stopped by selecting mode 3
// RULE13: overflow flag set by hardware, cleared on vector
// RULE14: irq flag set by type, cleared by software/vector
// RULE15: level mode flag follows inverted pin
// RULE16: type bit: 0 level low, 1 falling edge
// RULE17: mode 0 is thirteen bits, wraps at 0x1FFF
// RULE18: mode field 00,01,10,11 encoding
// RULE19: event pin levels held two clocks minimum
// RULE20: pins synchronised, edges from sampled values
// RULE21: cpu byte write beats increment or reload
`ifndef DLT_CONSTS_SVH
`define DLT_CONSTS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DLT_ADDR_CTRL 8'h88
`define DLT_ADDR_MODE 8'h8C
`define DLT_ADDR_CKSEL 8'h90
`define DLT_ADDR_CLA 8'h94
`define DLT_ADDR_CHA 8'h98
`define DLT_ADDR_CLB 8'h9C
`define DLT_ADDR_CHB 8'hA0
`define DLT_ADDR_IEN 8'hA4
`define DLT_ADDR_ACK 8'hA8
// ----------------------------------------
// control/status fields
// ----------------------------------------
`define DLT_TF_B 7
`define DLT_TR_B 6
`define DLT_TF_A 5
`define DLT_TR_A 4
`define DLT_IE_B 3
`define DLT_IT_B 2
`define DLT_IE_A 1
`define DLT_IT_A 0
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define DLT_GATE_B 7
`define DLT_CT_B 6
`define DLT_MODE_B_HI 5
`define DLT_MODE_B_LO 4
`define DLT_GATE_A 3
`define DLT_CT_A 2
`define DLT_MODE_A_HI 1
`define DLT_MODE_A_LO 0
// ----------------------------------------
// clock select fields and prescale
// ----------------------------------------
`define DLT_SYSSEL_B 4
`define DLT_SYSSEL_A 3
`define DLT_SCA_HI 1
`define DLT_SCA_LO 0
`define DLT_DIV12 8'd11
`define DLT_DIV4 8'd3
`define DLT_DIV48 8'd47
`define DLT_DIV8 8'd7
`define DLT_RESET_BYTE 8'h00
`define DLT_RESP_OKAY 2'b00
`define DLT_RESP_SLVERR 2'b10
`endif

// [pkg/dlt_pkg.sv]
// types for the dual legacy counter/timer block
package dlt_pkg;
    typedef enum logic [1:0] {DLT_M13, DLT_M16, DLT_M8R, DLT_MSPLIT} dlt_mode_e;
    typedef logic [7:0] dlt_byte_t;
endpackage : dlt_pkg

// [verif/dlt_pin_drv.sv]
// external event source: n falling edges, each level held three clocks
module dlt_pin_drv (
    input wire logic aclk,
    input wire logic start,
    input wire logic [3:0] n,
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] left;
    logic [2:0] ph;
    initial begin
        pin = 1'b1;
        left = 4'h0;
        ph = 3'h0;
    end
    always @(posedge aclk) begin
        if (start) begin
            left <= n;
            ph <= 3'h0;
        end else if (left != 4'h0) begin
            ph <= ph + 3'h1;
            if (ph == 3'h2) pin <= 1'b0;
            if (ph == 3'h5) begin
                pin <= 1'b1;
                ph <= 3'h0;
                left <= left - 4'h1;
            end
        end
    end
endmodule : dlt_pin_drv

// [verif/dlt_timers_bench.sv]
// self-checking testbench for the dual legacy counter/timer block
`include "dlt_consts.svh"
module dlt_timers_bench
    import dlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, v, seed;
    logic [3:0] s_axi_wstrb, ev_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ev_go;
    logic event_pin_a, event_pin_b, ext_irq_a_n, ext_irq_b_n;
    logic timer_irq_a, timer_irq_b, ext_irq_a, ext_irq_b, overflow_pulse_b;
    int error_cnt, tests_run, e, n, pulses;
    dlt_timers dut(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .event_pin_a(event_pin_a), .event_pin_b(event_pin_b),
        .ext_irq_a_n(ext_irq_a_n), .ext_irq_b_n(ext_irq_b_n), .timer_irq_a(timer_irq_a),
        .timer_irq_b(timer_irq_b), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
        .overflow_pulse_b(overflow_pulse_b));
    dlt_pin_drv pa(.aclk(aclk), .start(ev_go), .n(ev_n), .pin(event_pin_a));
    dlt_pin_drv pb(.aclk(aclk), .start(ev_go), .n(ev_n), .pin(event_pin_b));
    wire [1:0] tirq = {timer_irq_b, timer_irq_a};
    always @(posedge aclk) begin
        if (overflow_pulse_b === 1'b1) pulses <= pulses + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        tests_run++;
        if (s !== ex) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        final_report;
    end
    initial begin
        logic [7:0] ra[3] = '{`DLT_ADDR_MODE, `DLT_ADDR_CKSEL, `DLT_ADDR_IEN};
        logic [7:0] rm[3] = '{8'hFF, 8'h1B, 8'h03};
        logic [7:0] ilo[3] = '{8'h1C, 8'hFC, 8'hFC};
        logic [7:0] ihi[3] = '{8'hFF, 8'hFF, 8'hC0};
        logic [7:0] ehi[3] = '{8'h00, 8'h00, 8'hC0};
        int dv[4] = '{`DLT_DIV12 + 1, `DLT_DIV4 + 1, `DLT_DIV48 + 1, `DLT_DIV8 + 1};
        seed = 32'h23F9;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ev_go} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev_n} = '0;
        {ext_irq_a_n, ext_irq_b_n} = 2'b11;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`DLT_ADDR_CTRL);
        chk("ctrl_reset", 32'h0, rv);
        wr(8'hB0, 8'h5A);
        chk("wr_unmapped", `DLT_RESP_SLVERR, rr);
        rd(8'hB0);
        chk("rd_unmapped", `DLT_RESP_SLVERR, rr);
        rd(`DLT_ADDR_ACK);
        chk("ack_reads_zero", 32'h0, rv);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            for (int k = 0; k < 3; k++) begin
                wr(ra[k], v[7:0]);
                rd(ra[k]);
                chk("readback", {24'h0, v[7:0] & rm[k]}, rv);
            end
        end
        $display("test registers done");
        wr(`DLT_ADDR_IEN, 8'h03);
        wr(`DLT_ADDR_CKSEL, 8'h18);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                wr(`DLT_ADDR_MODE, 8'(m << (4 * t)));
                wr(t ? `DLT_ADDR_CLB : `DLT_ADDR_CLA, ilo[m]);
                wr(t ? `DLT_ADDR_CHB : `DLT_ADDR_CHA, ihi[m]);
                wr(`DLT_ADDR_CTRL, t ? 8'h40 : 8'h10);
                for (int k = 0; k < 60 && tirq[t] !== 1'b1; k++) @(posedge aclk);
                chk("timer_irq", 32'h1, tirq[t]);
                rd(`DLT_ADDR_CTRL);
                chk("overflow_flag", t ? 32'hC0 : 32'h30, rv);
                wr(`DLT_ADDR_CTRL, t ? 8'h80 : 8'h20);
                rd(t ? `DLT_ADDR_CHB : `DLT_ADDR_CHA);
                chk("count_high", ehi[m], rv);
                rd(t ? `DLT_ADDR_CLB : `DLT_ADDR_CLA);
                if (m == 2) chk("reload_low", 32'h3, rv[7:6]);
                wr(`DLT_ADDR_ACK, 8'(t + 1));
                rd(`DLT_ADDR_CTRL);
                chk("flag_cleared", 32'h0, rv);
                chk("irq_cleared", 32'h0, tirq[t]);
            end
        end
        $display("test modes done");
        wr(`DLT_ADDR_MODE, 8'h09);
        wr(`DLT_ADDR_CKSEL, 8'h08);
        wr(`DLT_ADDR_CLA, 8'h55);
        {ext_irq_a_n, ext_irq_b_n} <= 2'b00;
        wr(`DLT_ADDR_CTRL, 8'h10);
        repeat (20) @(posedge aclk);
        rd(`DLT_ADDR_CLA);
        chk("gated_hold", 32'h55, rv);
        chk("level_flag", 32'h1, ext_irq_a);
        chk("level_flag_b", 32'h1, ext_irq_b);
        {ext_irq_a_n, ext_irq_b_n} <= 2'b11;
        repeat (20) @(posedge aclk);
        rd(`DLT_ADDR_CLA);
        chk("gate_open", 32'h1, rv > 32'h55);
        chk("level_release", 32'h0, ext_irq_a);
        chk("level_release_b", 32'h0, ext_irq_b);
        wr(`DLT_ADDR_CTRL, 8'h00);
        $display("test gate done");
        wr(`DLT_ADDR_MODE, 8'h55);
        wr(`DLT_ADDR_CLA, 8'h00);
        wr(`DLT_ADDR_CLB, 8'h00);
        wr(`DLT_ADDR_CTRL, 8'h50);
        n = int'(rnd() % 15) + 1;
        ev_n <= 4'(n);
        ev_go <= 1'b1;
        @(posedge aclk);
        ev_go <= 1'b0;
        repeat (n * 6 + 12) @(posedge aclk);
        wr(`DLT_ADDR_CTRL, 8'h00);
        rd(`DLT_ADDR_CLA);
        chk("event_count", n, rv);
        rd(`DLT_ADDR_CLB);
        chk("event_count_b", n, rv);
        $display("test events done");
        wr(`DLT_ADDR_MODE, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(`DLT_ADDR_CKSEL, 8'(s));
            wr(`DLT_ADDR_CLA, 8'h00);
            wr(`DLT_ADDR_CTRL, 8'h10);
            repeat (480) @(posedge aclk);
            wr(`DLT_ADDR_CTRL, 8'h00);
            rd(`DLT_ADDR_CLA);
            e = 480 / dv[s];
            chk("prescale", 32'h1, rv + 1 >= e && rv <= e + 2);
        end
        $display("test prescale done");
        wr(`DLT_ADDR_CTRL, 8'h01);
        ext_irq_a_n <= 1'b0;
        repeat (4) @(posedge aclk);
        ext_irq_a_n <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("edge_flag", 32'h1, ext_irq_a);
        wr(`DLT_ADDR_ACK, 8'h04);
        repeat (3) @(posedge aclk);
        chk("edge_clear", 32'h0, ext_irq_a);
        $display("test edge irq done");
        wr(`DLT_ADDR_MODE, 8'h23);
        wr(`DLT_ADDR_CKSEL, 8'h18);
        wr(`DLT_ADDR_CLB, 8'hF0);
        wr(`DLT_ADDR_CHA, 8'hF8);
        e = pulses;
        repeat (40) @(posedge aclk);
        rd(`DLT_ADDR_CTRL);
        chk("split_no_flag", 32'h0, rv & 32'h80);
        chk("split_pulse", 32'h1, pulses > e);
        wr(`DLT_ADDR_CTRL, 8'h40);
        for (int k = 0; k < 60 && timer_irq_b !== 1'b1; k++) @(posedge aclk);
        chk("split_irq", 32'h1, timer_irq_b);
        rd(`DLT_ADDR_CTRL);
        chk("split_flag", 32'h80, rv & 32'h80);
        wr(`DLT_ADDR_MODE, 8'h33);
        rd(`DLT_ADDR_CLB);
        v = rv;
        repeat (20) @(posedge aclk);
        rd(`DLT_ADDR_CLB);
        chk("split_b_stop", v, rv);
        wr(`DLT_ADDR_CTRL, 8'h00);
        $display("test split done");
        final_report;
    end
endmodule : dlt_timers_bench

// [verif/dlt_timers_chk.sv]
// port-level checker for the dual legacy counter/timer block
`include "dlt_consts.svh"
module dlt_timers_chk
    import dlt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_a_n,
    input wire logic ext_irq_b_n,
    input wire logic ext_irq_a,
    input wire logic ext_irq_b
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // pin low history
    // ----------------------------------------
    logic [5:0] low_a_q;
    logic [5:0] low_b_q;
    always_ff @(posedge aclk) begin
        low_a_q <= {low_a_q[4:0], ~ext_irq_a_n};
        low_b_q <= {low_b_q[4:0], ~ext_irq_b_n};
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second address taken");
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    ext_rise_a_a: assert property ($rose(ext_irq_a) |-> low_a_q != 6'h00)
        else $error("irq flag a set without low pin");
    ext_rise_b_a: assert property ($rose(ext_irq_b) |-> low_b_q != 6'h00)
        else $error("irq flag b set without low pin");
endmodule : dlt_timers_chk

bind dlt_timers dlt_timers_chk u_chk(.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_irq_a_n(ext_irq_a_n), .ext_irq_b_n(ext_irq_b_n),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b));
